// ==== umpaf_pkg.sv ====
// Package: constants and carriers for the multi-drop address filter
package umpaf_pkg;
  // ****************************************************************
  // Register offsets (byte addresses, plain register port)
  // ****************************************************************
  localparam logic [3:0] UMPAF_OFF_CSA = 4'h0;
  localparam logic [3:0] UMPAF_OFF_CSB = 4'h4;
  localparam logic [3:0] UMPAF_OFF_SHARED = 4'h8;
  localparam logic [3:0] UMPAF_OFF_DATA = 4'hC;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int UMPAF_CSA_RXC = 7;
  localparam int UMPAF_CSA_TXC = 6;
  localparam int UMPAF_CSA_FILT = 0;
  localparam int UMPAF_CSB_SIZE2 = 2;
  localparam int UMPAF_CSB_RX9 = 1;
  localparam int UMPAF_CSB_TX9 = 0;
  localparam int UMPAF_SEL_BIT = 7;
  localparam int UMPAF_CSC_STOP2 = 3;
  localparam int UMPAF_CSC_SIZE_LO = 1;
  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [6:0] UMPAF_CSC_RST = 7'h06;
  localparam logic [7:0] UMPAF_BAUDH_RST = 8'h00;
  localparam logic [2:0] UMPAF_SIZE_NINE = 3'h7;
  localparam int UMPAF_RXQ_DEPTH = 2;

  // Received frame as delivered by the bit-level receiver
  typedef struct packed {
    logic [8:0] data;
    logic first_stop;
  } umpaf_frame_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } umpaf_req_t;
endpackage : umpaf_pkg

// ==== umpaf_classify.sv ====
// Frame-type classifier: picks the type bit and decides acceptance
`timescale 1ns/10ps
module umpaf_classify (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Frame in
  input wire logic frame_valid,
  input wire umpaf_pkg::umpaf_frame_t frame,
  input wire logic [2:0] char_size_code,
  input wire logic addr_filter_enable,
  // Decision
  output logic is_addr,
  output logic accept
);
  import umpaf_pkg::*;

  logic type_bit;

  always_comb begin
    // Nine-bit frames use bit 8, shorter ones the first stop bit
    if (char_size_code == UMPAF_SIZE_NINE) begin
      type_bit = frame.data[8];
    end else begin
      type_bit = frame.first_stop;
    end
    is_addr = type_bit;
    accept = frame_valid
      && (!addr_filter_enable || type_bit);
  end

  filt_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && addr_filter_enable && !is_addr |-> !accept)
    else $error("data frame accepted while filtering");
  nine_type_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    char_size_code == UMPAF_SIZE_NINE |-> is_addr == frame.data[8])
    else $error("nine-bit type bit wrong");
  short_type_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    char_size_code != UMPAF_SIZE_NINE |-> is_addr == frame.first_stop)
    else $error("stop-bit type bit wrong");
  nofilt_pass_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && !addr_filter_enable |-> accept)
    else $error("frame lost with filter off");
endmodule : umpaf_classify

// ==== umpaf_top.sv ====
// Address filter, receive buffer and shared-location register access
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
module umpaf_top #(
  parameter int DEPTH = umpaf_pkg::UMPAF_RXQ_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire umpaf_pkg::umpaf_req_t req,
  output logic [7:0] rdata,
  // Bit-level receiver
  input wire logic rx_frame_valid,
  input wire umpaf_pkg::umpaf_frame_t rx_frame,
  // Bit-level transmitter
  input wire logic tx_done,
  output logic [2:0] char_size_code,
  output logic two_stop_select,
  output logic tx_ninth_bit,
  output logic [7:0] tx_data,
  output logic tx_load,
  output logic [7:0] baud_divisor_high
);
  import umpaf_pkg::*;

  // Elaboration check: the buffer count is four bits wide
  if (DEPTH < 1 || DEPTH > 8) begin : g_bad_depth
    $error("DEPTH must be 1 to 8");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] rdata;
    logic filt;
    logic tx_complete_flag;
    logic size2;
    logic tx9;
    logic [6:0] csc;
    logic [7:0] baudh;
    logic shared_rd;
    logic [7:0] txd;
    logic txl;
    logic [DEPTH-1:0][8:0] buf_mem;
    logic [3:0] count;
  } umpaf_state_t;

  umpaf_state_t s_q;
  umpaf_state_t s_d;
  logic is_addr;
  logic accept;
  logic [2:0] size_code;

  assign size_code = {s_q.size2, s_q.csc[UMPAF_CSC_SIZE_LO +: 2]};

  umpaf_classify u_cls (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .frame_valid(rx_frame_valid),
    .frame(rx_frame),
    .char_size_code(size_code),
    .addr_filter_enable(s_q.filt),
    .is_addr(is_addr),
    .accept(accept)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic pop;
    logic push;
    logic [7:0] csa;
    pop = 1'b0;
    push = 1'b0;
    csa = 8'h00;
    s_d = s_q;
    s_d.txl = 1'b0;
    s_d.shared_rd = 1'b0;
    s_d.rdata = 8'h00;
    csa[UMPAF_CSA_RXC] = (s_q.count != 4'h0);
    csa[UMPAF_CSA_TXC] = s_q.tx_complete_flag;
    csa[UMPAF_CSA_FILT] = s_q.filt;
    // Register writes
    if (req.wr) begin
      if (req.addr == UMPAF_OFF_CSA) begin
        s_d.filt = req.wdata[UMPAF_CSA_FILT];
        if (req.wdata[UMPAF_CSA_TXC]) begin
          s_d.tx_complete_flag = 1'b0;
        end
      end else if (req.addr == UMPAF_OFF_CSB) begin
        s_d.size2 = req.wdata[UMPAF_CSB_SIZE2];
        s_d.tx9 = req.wdata[UMPAF_CSB_TX9];
      end else if (req.addr == UMPAF_OFF_SHARED) begin
        if (req.wdata[UMPAF_SEL_BIT]) begin
          s_d.csc = req.wdata[6:0];
        end else begin
          s_d.baudh = req.wdata;
        end
      end else if (req.addr == UMPAF_OFF_DATA) begin
        s_d.txd = req.wdata;
        s_d.txl = 1'b1;
      end
    end
    // Register reads
    if (req.rd) begin
      if (req.addr == UMPAF_OFF_CSA) begin
        s_d.rdata = csa;
      end else if (req.addr == UMPAF_OFF_CSB) begin
        s_d.rdata = {5'h00, s_q.size2, s_q.buf_mem[0][8], s_q.tx9};
      end else if (req.addr == UMPAF_OFF_SHARED) begin
        s_d.shared_rd = 1'b1;
        if (s_q.shared_rd) begin
          s_d.rdata = {1'b1, s_q.csc};
        end else begin
          s_d.rdata = s_q.baudh;
        end
      end else if (req.addr == UMPAF_OFF_DATA) begin
        s_d.rdata = s_q.buf_mem[0][7:0];
        pop = (s_q.count != 4'h0);
      end
    end
    // Set wins over a same-cycle clear
    if (tx_done) begin
      s_d.tx_complete_flag = 1'b1;
    end
    // Receive buffer; a full buffer drops the new frame unless a same-cycle data read pops an entry
    push = accept && (s_q.count - {3'h0, pop} < 4'(DEPTH));
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        s_d.buf_mem[i] = s_q.buf_mem[i + 1];
      end
    end
    if (push) begin
      s_d.buf_mem[s_q.count - {3'h0, pop}] = rx_frame.data;
    end
    s_d.count = s_q.count - {3'h0, pop} + {3'h0, push};
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.csc <= UMPAF_CSC_RST;
      s_q.baudh <= UMPAF_BAUDH_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata = s_q.rdata;
  assign char_size_code = size_code;
  assign two_stop_select = s_q.csc[UMPAF_CSC_STOP2];
  assign tx_ninth_bit = s_q.tx9;
  assign tx_data = s_q.txd;
  assign tx_load = s_q.txl;
  assign baud_divisor_high = s_q.baudh;

  // ****************************************************************
  // Checks
  // ****************************************************************
  shared_pair_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    req.rd && req.addr == UMPAF_OFF_SHARED ##1
      req.rd && req.addr == UMPAF_OFF_SHARED
      |=> rdata == {1'b1, $past(s_q.csc)})
    else $error("second shared read not control C");
  shared_single_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !s_q.shared_rd && req.rd && req.addr == UMPAF_OFF_SHARED
      |=> rdata == $past(s_q.baudh))
    else $error("single shared read not baud high");
  flag_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(req.rd && req.addr == UMPAF_OFF_SHARED) |=> !s_q.shared_rd)
    else $error("shared read flag held");
  sel_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    req.wr && req.addr == UMPAF_OFF_SHARED && !req.wdata[7]
      |=> baud_divisor_high == $past(req.wdata) && $stable(s_q.csc))
    else $error("baud high write wrong");
  addr_store_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rx_frame_valid && is_addr && s_q.count == 4'h0 |=> s_q.count == 4'h1)
    else $error("address frame not stored");
  drop_count_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rx_frame_valid && s_q.filt && !is_addr && !req.rd
      |=> s_q.count == $past(s_q.count))
    else $error("data frame stored while filtering");
  txc_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    req.wr && req.addr == UMPAF_OFF_CSA && req.wdata[6] && !tx_done
      |=> !s_q.tx_complete_flag)
    else $error("transmit complete not cleared");
  txc_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tx_done |=> s_q.tx_complete_flag)
    else $error("transmit complete not set");
  csc_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    req.wr && req.addr == UMPAF_OFF_SHARED && req.wdata[UMPAF_SEL_BIT]
      |=> s_q.csc == $past(req.wdata[6:0])
        && $stable(baud_divisor_high))
    else $error("control C write wrong");
  filt_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    req.wr && req.addr == UMPAF_OFF_CSA
      |=> s_q.filt == $past(req.wdata[UMPAF_CSA_FILT]))
    else $error("filter enable write lost");
  size_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    req.wr && req.addr == UMPAF_OFF_CSB
      |=> char_size_code[2] == $past(req.wdata[2]))
    else $error("size write not shared");
  rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !req.rd |=> rdata == 8'h00)
    else $error("read data outside read cycle");
  full_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rx_frame_valid && s_q.count == 4'(DEPTH) && !req.rd
      |=> s_q.count == 4'(DEPTH))
    else $error("frame stored into full buffer");
  tx_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    req.wr && req.addr == UMPAF_OFF_DATA
      |=> tx_load && tx_data == $past(req.wdata))
    else $error("transmit load wrong");
  tx_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(req.wr && req.addr == UMPAF_OFF_DATA) |=> !tx_load)
    else $error("transmit load without write");

  // ****************************************************************
  // Cover points
  // ****************************************************************
  cv_pair_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    req.rd && req.addr == UMPAF_OFF_SHARED ##1
      req.rd && req.addr == UMPAF_OFF_SHARED);
  cv_drop_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    rx_frame_valid && s_q.filt && !is_addr);
  cv_addr_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    rx_frame_valid && s_q.filt && is_addr);
  cv_full_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    rx_frame_valid && accept && s_q.count == 4'(DEPTH));
  cv_nofilt_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    rx_frame_valid && !s_q.filt && !is_addr);
endmodule : umpaf_top

// ==== umpaf_node_model.sv ====
// Far-side serial node: feeds received frames, answers transmit loads
`timescale 1ns/10ps
module umpaf_node_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Command from bench
  input wire logic go,
  input wire umpaf_pkg::umpaf_frame_t go_frame,
  // Device side
  input wire logic tx_load,
  output logic rx_frame_valid,
  output umpaf_pkg::umpaf_frame_t rx_frame,
  output logic tx_done
);
  import umpaf_pkg::*;
  logic [1:0] cnt_q;
  logic busy_q;
  // Frame type rides in bit 8 or in the first of two stop bits
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_frame_valid <= 1'h0;
      rx_frame <= '0;
      tx_done <= 1'h0;
      busy_q <= 1'h0;
      cnt_q <= 2'h0;
    end else begin
      rx_frame_valid <= go;
      // Outside a frame the lines toggle between the last frame and its complement
      rx_frame <= go ? go_frame : ~rx_frame;
      tx_done <= busy_q && (cnt_q == 2'h3);
      if (tx_load) begin
        busy_q <= 1'h1;
        cnt_q <= 2'h0;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 2'h1;
        if (cnt_q == 2'h3) busy_q <= 1'h0;
      end
    end
  end
endmodule : umpaf_node_model

// ==== uart_multiproc_addr_filter_tb.sv ====
// Self-checking bench for the address filter and shared location
`timescale 1ns/10ps
module uart_multiproc_addr_filter_tb;
  import umpaf_pkg::*;
  typedef struct packed {
    logic s9; logic filt; logic [8:0] d; logic st; logic acc;
  } umpaf_row_t;
  logic clk_sys, rst_n, rx_frame_valid, tx_done, go;
  logic two_stop_select, tx_ninth_bit, tx_load;
  logic [7:0] rdata, tx_data, baud_divisor_high;
  logic [2:0] char_size_code;
  umpaf_req_t req;
  umpaf_frame_t rx_frame, go_frame;
  int n_errors, cmp_count;
  umpaf_row_t rows [6];
  umpaf_top #(.DEPTH(2)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .req(req), .rdata(rdata), .rx_frame_valid(rx_frame_valid),
    .rx_frame(rx_frame), .tx_done(tx_done),
    .char_size_code(char_size_code), .two_stop_select(two_stop_select),
    .tx_ninth_bit(tx_ninth_bit), .tx_data(tx_data), .tx_load(tx_load),
    .baud_divisor_high(baud_divisor_high));
  umpaf_node_model u_node (.clk_sys(clk_sys), .rst_n(rst_n), .go(go),
    .go_frame(go_frame), .tx_load(tx_load),
    .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame),
    .tx_done(tx_done));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("Error t=%0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask : cmp
  task automatic issue(input logic [3:0] a, input logic [7:0] d,
                       input logic w, input logic r);
    @(posedge clk_sys);
    req <= {a, d, w, r};
  endtask : issue
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    issue(a, d, 1'h1, 1'h0);
    issue(4'h0, 8'h00, 1'h0, 1'h0);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    issue(a, 8'h00, 1'h0, 1'h1);
    issue(4'h0, 8'h00, 1'h0, 1'h0);
    @(negedge clk_sys);
  endtask : rd
  task automatic shared_rd(input int n, input logic [7:0] first,
                           input logic [7:0] rest);
    issue(UMPAF_OFF_SHARED, 8'h00, 1'h0, 1'h1);
    for (int i = 0; i < n; i++) begin
      issue(UMPAF_OFF_SHARED, 8'h00, 1'h0, i < n - 1);
      @(negedge clk_sys);
      cmp(9'(rdata), 9'(i == 0 ? first : rest));
    end
  endtask : shared_rd
  task automatic send(input logic [8:0] d, input logic st);
    @(posedge clk_sys);
    go <= 1'h1;
    go_frame <= {d, st};
    @(posedge clk_sys);
    go <= 1'h0;
    repeat (3) @(posedge clk_sys);
  endtask : send
  task automatic end_sim;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // ****************************************************************
  // Clock, watchdog and tests
  // ****************************************************************
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end
  initial begin
    rows = '{'{1'h1, 1'h1, 9'h1A5, 1'h0, 1'h1},
             '{1'h1, 1'h1, 9'h05A, 1'h1, 1'h0},
             '{1'h1, 1'h0, 9'h03C, 1'h0, 1'h1},
             '{1'h0, 1'h1, 9'h0C3, 1'h1, 1'h1},
             '{1'h0, 1'h1, 9'h199, 1'h0, 1'h0},
             '{1'h0, 1'h0, 9'h011, 1'h0, 1'h1}};
    rst_n = 1'h0; req = '0; go = 1'h0; go_frame = '0;
    n_errors = 0; cmp_count = 0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'h1;
    foreach (rows[i]) begin
      wr(UMPAF_OFF_CSB, {5'h00, rows[i].s9, 2'h0});
      wr(UMPAF_OFF_CSA, {7'h00, rows[i].filt});
      cmp(9'(char_size_code), rows[i].s9 ? 9'h7 : 9'h3);
      send(rows[i].d, rows[i].st);
      rd(UMPAF_OFF_CSA);
      cmp(9'(rdata[7]), 9'(rows[i].acc));
      if (rows[i].acc) begin
        if (rows[i].s9) begin
          rd(UMPAF_OFF_CSB);
          cmp(9'(rdata[1]), 9'(rows[i].d[8]));
        end
        rd(UMPAF_OFF_DATA);
        cmp(9'(rdata), 9'(rows[i].d[7:0]));
      end
    end
    // Shared location: reset contents, steered writes, timed reads
    shared_rd(2, UMPAF_BAUDH_RST, {1'h1, UMPAF_CSC_RST});
    wr(UMPAF_OFF_SHARED, 8'h02);
    wr(UMPAF_OFF_SHARED, 8'h8E);
    @(negedge clk_sys);
    cmp(9'(baud_divisor_high), 9'h02);
    cmp(9'(two_stop_select), 9'h1);
    shared_rd(1, 8'h02, 8'h02);
    shared_rd(3, 8'h02, 8'h8E);
    issue(UMPAF_OFF_SHARED, 8'h00, 1'h0, 1'h1);
    issue(UMPAF_OFF_CSA, 8'h00, 1'h0, 1'h1);
    rd(UMPAF_OFF_SHARED);
    cmp(9'(rdata), 9'h02);
    rd(4'h2);
    cmp(9'(rdata), 9'h00);
    // Buffer overflow drops the third frame
    wr(UMPAF_OFF_CSB, 8'h04);
    wr(UMPAF_OFF_CSA, 8'h00);
    for (int i = 1; i <= 3; i++) send(9'h100 + 9'(i), 1'h0);
    for (int i = 1; i <= 2; i++) begin
      rd(UMPAF_OFF_DATA);
      cmp(9'(rdata), 9'(i));
    end
    rd(UMPAF_OFF_CSA);
    cmp(9'(rdata[7]), 9'h0);
    // Addressed slave: address, filter off for data, filter back on
    wr(UMPAF_OFF_CSA, 8'h01);
    send(9'h103, 1'h0);
    send(9'h044, 1'h0);
    rd(UMPAF_OFF_DATA);
    cmp(9'(rdata), 9'h03);
    wr(UMPAF_OFF_CSA, 8'h00);
    send(9'h055, 1'h0);
    wr(UMPAF_OFF_CSA, 8'h01);
    send(9'h066, 1'h0);
    rd(UMPAF_OFF_DATA);
    cmp(9'(rdata), 9'h55);
    rd(UMPAF_OFF_CSA);
    cmp(9'(rdata), 9'h01);
    // Transmit path with filter on, then write-one clear
    wr(UMPAF_OFF_CSA, 8'h01);
    wr(UMPAF_OFF_CSB, 8'h05);
    @(negedge clk_sys);
    cmp(9'(tx_ninth_bit), 9'h1);
    issue(UMPAF_OFF_DATA, 8'h5A, 1'h1, 1'h0);
    issue(4'h0, 8'h00, 1'h0, 1'h0);
    @(negedge clk_sys);
    cmp({tx_load, tx_data}, 9'h15A);
    repeat (6) @(posedge clk_sys);
    rd(UMPAF_OFF_CSA);
    cmp(9'(rdata), 9'h41);
    wr(UMPAF_OFF_CSA, 8'h41);
    rd(UMPAF_OFF_CSA);
    cmp(9'(rdata), 9'h01);
    // Mid-run reset returns every setting to its default
    @(posedge clk_sys);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(negedge clk_sys);
    cmp(9'(char_size_code), 9'h3);
    cmp(9'(baud_divisor_high), 9'(UMPAF_BAUDH_RST));
    cmp(9'(two_stop_select), 9'h0);
    cmp(9'(tx_ninth_bit), 9'h0);
    rd(UMPAF_OFF_CSA);
    cmp(9'(rdata), 9'h00);
    shared_rd(2, UMPAF_BAUDH_RST, {1'h1, UMPAF_CSC_RST});
    end_sim();
  end
endmodule : uart_multiproc_addr_filter_tb
